// *** inc/cms_pkg.sv ***
// package: constants, types and helpers for the macrocell slice
package cms_pkg;
    localparam int NUM_MC = 16;
    localparam int NUM_IN = 5;
    localparam int NUM_GCLK = 4;
    localparam int NUM_ROUTE = 36;
    localparam int FIELD_W = 72;
    localparam int GRP = 4;
    localparam int NUM_TERM = 19;
    localparam int LANE_W = 24;
    localparam int NUM_LANE = 3;
    localparam int MEM_AW = 5;
    localparam int MEM_DEPTH = 32;
    localparam logic [4:0] TERM_SET = 5'h10;
    localparam logic [4:0] TERM_RST = 5'h11;
    localparam logic [4:0] TERM_CLK = 5'h12;
    localparam logic [4:0] TERM_LAST = 5'h12;
    // even macrocells own a pin, odd ones are buried
    localparam logic [15:0] MC_IO_MASK = 16'h5555;
    // register byte offsets
    localparam logic [11:0] OFF_CTRL = 12'h000;
    localparam logic [11:0] OFF_STATUS = 12'h004;
    localparam logic [11:0] OFF_PINS = 12'h008;
    localparam logic [11:0] OFF_MC = 12'h040;
    localparam logic [11:0] OFF_IN = 12'h080;
    localparam logic [11:0] OFF_MASK = 12'h200;
    // control register fields
    localparam int CT_FALL = 0;
    localparam int CT_SETINV = 1;
    localparam int CT_RSTINV = 2;
    localparam int CT_PTINV = 3;
    localparam int CT_CKINV = 4;
    localparam int CTRL_W = 8;
    localparam logic [7:0] CTRL_RST = 8'h00;
    // macrocell configuration fields
    localparam int MC_MODE = 0;
    localparam int MC_CLK = 2;
    localparam int MC_OINV = 5;
    localparam int MC_OE = 6;
    localparam int MC_INREG = 7;
    localparam int MC_TSEL = 8;
    localparam int MC_CFG_W = 12;
    localparam logic [11:0] MC_CFG_RST = 12'h000;
    // dedicated input configuration fields
    localparam int IN_MODE = 0;
    localparam int IN_CLK = 2;
    localparam int IN_CFG_W = 4;
    localparam logic [3:0] IN_CFG_RST = 4'h0;
    localparam logic [2:0] HSIZE_WORD = 3'h2;

    typedef enum logic [1:0] {
        CMS_COMB = 2'h0,
        CMS_DFF = 2'h1,
        CMS_TFF = 2'h2,
        CMS_LATCH = 2'h3
    } cms_mode_t;

    typedef enum logic [1:0] {
        CMS_IN_COMB = 2'h0,
        CMS_IN_REG = 2'h1,
        CMS_IN_DREG = 2'h2,
        CMS_IN_LATCH = 2'h3
    } cms_imode_t;

    typedef enum logic [3:0] {
        CMS_BUS_IDLE = 4'h1,
        CMS_BUS_WR = 4'h2,
        CMS_BUS_MRD = 4'h4,
        CMS_BUS_MDAT = 4'h8
    } cms_bus_t;

    // empty mask gives a false term
    function automatic logic cms_term_eval(input logic [71:0] mask,
                                           input logic [71:0] field);
        return (|mask) & (&(~mask | field));
    endfunction

    // edge detect, rising or falling
    function automatic logic cms_edge(input logic prev, input logic cur,
                                      input logic fall);
        return fall ? (prev & ~cur) : (~prev & cur);
    endfunction
endpackage

// *** inc/cms_mem_if.sv ***
// carrier between the slice and its term mask memory
`timescale 1ns/100ps
interface cms_mem_if;
    import cms_pkg::*;
    logic we;
    logic [NUM_LANE-1:0] lane_we;
    logic [MEM_AW-1:0] waddr;
    logic [LANE_W-1:0] wdata;
    logic [MEM_AW-1:0] raddr;
    logic [FIELD_W-1:0] rdata;
    modport ctl (output we, lane_we, waddr, wdata, raddr, input rdata);
    modport mem (input we, lane_we, waddr, wdata, raddr, output rdata);
endinterface

// *** design/cms_term_mem.sv ***
// little memory of product term masks with registered read
`timescale 1ns/100ps
module cms_term_mem
    import cms_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    cms_mem_if.mem port
);
    typedef struct packed {
        logic [MEM_DEPTH-1:0][FIELD_W-1:0] arr;
        logic [FIELD_W-1:0] rdata;
    } cms_mem_t;

    cms_mem_t s_q;
    cms_mem_t s_d;

    // lane writes, read returns the old word
    always_comb
    begin
        s_d = s_q;
        s_d.rdata = s_q.arr[port.raddr];
        for (int l = 0; l < NUM_LANE; l++)
        begin
            if (port.we && port.lane_we[l])
            begin
                s_d.arr[port.waddr][l*LANE_W +: LANE_W] = port.wdata;
            end
        end
    end

    // cleared masks read as unused terms
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            s_q <= '0;
        else if (ce)
            s_q <= s_d;
    end

    assign port.rdata = s_q.rdata;
endmodule

// *** design/cms_input_cell.sv ***
// dedicated input cell: comb, registered, double registered, latched
`timescale 1ns/100ps
module cms_input_cell
    import cms_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic pin,
    input wire logic cap,
    input wire logic lvl,
    input wire logic [1:0] mode,
    output logic dout
);
    typedef struct packed {
        logic st1;
        logic st2;
    } cms_icell_t;

    cms_icell_t s_q;
    cms_icell_t s_d;

    // capture stages
    always_comb
    begin
        s_d = s_q;
        unique case (cms_imode_t'(mode))
            CMS_IN_COMB: s_d.st1 = pin;
            CMS_IN_REG:
            begin
                if (cap) s_d.st1 = pin;
            end
            CMS_IN_DREG:
            begin
                if (cap)
                begin
                    s_d.st1 = pin;
                    s_d.st2 = s_q.st1;
                end
            end
            CMS_IN_LATCH:
            begin
                if (lvl) s_d.st1 = pin;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            s_q <= '0;
        else if (ce)
            s_q <= s_d;
    end

    // output select, latch transparent while level high
    assign dout = (mode == CMS_IN_DREG) ? s_q.st2 :
                  (mode == CMS_IN_COMB) ? pin :
                  (mode == CMS_IN_LATCH && lvl) ? pin : s_q.st1;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    property p_dbl_reg;
        ce && mode == CMS_IN_DREG && cap |=> s_q.st2 == $past(s_q.st1);
    endproperty
    a_dbl_reg: assert property (p_dbl_reg)
        else $error("second input stage missed first stage");
endmodule

// *** design/cms_slice.sv ***
// macrocell slice: ahb-lite registers, product terms, cells, inputs
// Overview of operation
// - sixteen macrocells, each io or buried
// - register modes comb, D, T, latch
// - block set forces one, reset forces zero
// - set and reset terms have polarity inversion
// - clock from four global or term clock
// - edge polarity chosen once per block
// - buried cell registers adjacent pin input
// - buried output always feeds routing matrix
// - io output polarity mux toward pin
// - feedback path separate from pin input
// - keeper holds last pin level when released
// - product terms shared in groups of four
// - inputs comb, registered, double, or latched
// - input capture uses selected global clock
// - input/clock pins drive clocks, invertible
// - block term clock, polarity, all cells
// - 36 routing signals plus complements form field
//
// Our own choices: the register offsets and the AHB-Lite slave port.
`timescale 1ns/100ps
module cms_slice
    import cms_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic [NUM_ROUTE-1:0] route_in,
    input wire logic [NUM_IN-1:0] in_pin,
    input wire logic [NUM_MC-1:0] io_pin_i,
    output logic [NUM_MC-1:0] io_pin_o,
    output logic [NUM_MC-1:0] io_pin_oe,
    output logic [NUM_MC-1:0] io_keep_o,
    output logic [NUM_MC-1:0] mc_to_matrix,
    output logic [NUM_MC-1:0] pin_to_matrix,
    output logic [NUM_IN-1:0] in_to_matrix
);
    typedef struct packed {
        cms_bus_t bst;
        logic [11:0] baddr;
        logic [CTRL_W-1:0] ctrl;
        logic [NUM_MC-1:0][MC_CFG_W-1:0] mccfg;
        logic [NUM_IN-1:0][IN_CFG_W-1:0] incfg;
        logic [31:0] hrdata;
        logic [MEM_AW-1:0] sw_idx;
        logic ev_vld;
        logic [MEM_AW-1:0] ev_idx;
        logic [NUM_TERM-1:0] term;
        logic [NUM_GCLK:0] prev;
        logic [NUM_MC-1:0] mcq;
        logic [NUM_MC-1:0] fb;
        logic [NUM_MC-1:0] pino;
        logic [NUM_MC-1:0] hold;
        logic [NUM_MC-1:0] io_s1;
        logic [NUM_MC-1:0] io_s2;
        logic [NUM_IN-1:0] in_s1;
        logic [NUM_IN-1:0] in_s2;
    } cms_slice_t;

    localparam cms_slice_t SLICE_RST = '{bst: CMS_BUS_IDLE,
                                         ctrl: CTRL_RST, default: '0};

    cms_slice_t s_q;
    cms_slice_t s_d;
    cms_mem_if mem_if ();

    logic global_sync_clock_a;
    logic global_sync_clock_b;
    logic global_sync_clock_c;
    logic global_sync_clock_d;
    logic block_term_clock;
    logic [NUM_GCLK-1:0] gclk;
    logic [NUM_GCLK-1:0] gedge;
    logic [NUM_GCLK:0] src;
    logic [7:0] edge_v;
    logic [7:0] lvl_v;
    logic set_act;
    logic rst_act;
    logic [FIELD_W-1:0] field;
    logic [NUM_MC-1:0] mc_data;
    logic [NUM_MC-1:0] mc_edge;
    logic [NUM_MC-1:0] mc_lvl;
    logic [NUM_MC-1:0] mc_out;
    logic acc;

    function automatic logic is_mask(input logic [11:0] a);
        return a[11:9] == OFF_MASK[11:9] && a[3:2] != 2'h3 &&
               a[8:4] <= TERM_LAST;
    endfunction

    function automatic logic is_mc(input logic [11:0] a);
        return a[11:6] == OFF_MC[11:6];
    endfunction

    function automatic logic is_in(input logic [11:0] a);
        return a[11:5] == OFF_IN[11:5] && a[4:2] < 3'(NUM_IN);
    endfunction

    function automatic logic [LANE_W-1:0] lane_of(
        input logic [FIELD_W-1:0] w, input logic [1:0] l);
        logic [LANE_W-1:0] r;
        r = w[LANE_W-1:0];
        if (l == 2'h1) r = w[2*LANE_W-1:LANE_W];
        if (l == 2'h2) r = w[3*LANE_W-1:2*LANE_W];
        return r;
    endfunction

    function automatic logic mc_next(input logic [1:0] mode, input logic q,
                                     input logic d, input logic ed,
                                     input logic lv);
        logic r;
        r = q;
        unique case (cms_mode_t'(mode))
            CMS_COMB: r = d;
            CMS_DFF:
            begin
                if (ed) r = d;
            end
            CMS_TFF:
            begin
                if (ed) r = q ^ d;
            end
            CMS_LATCH:
            begin
                if (lv) r = d;
            end
        endcase
        return r;
    endfunction

    // clock distribution from input/clock pins and block term
    assign {global_sync_clock_d, global_sync_clock_c, global_sync_clock_b,
            global_sync_clock_a} = s_q.in_s2[4:1] ^ s_q.ctrl[CT_CKINV +: 4];
    assign gclk = {global_sync_clock_d, global_sync_clock_c,
                   global_sync_clock_b, global_sync_clock_a};
    assign block_term_clock = s_q.term[TERM_CLK] ^ s_q.ctrl[CT_PTINV];
    assign src = {block_term_clock, gclk};

    // one polarity choice for all macrocells, input capture edges always rising
    always_comb
    begin
        edge_v = 8'h00;
        lvl_v = 8'h00;
        for (int k = 0; k <= NUM_GCLK; k++)
        begin
            edge_v[k] = cms_edge(s_q.prev[k], src[k], s_q.ctrl[CT_FALL]);
            lvl_v[k] = src[k] ^ s_q.ctrl[CT_FALL];
        end
        for (int k = 0; k < NUM_GCLK; k++)
        begin
            gedge[k] = cms_edge(s_q.prev[k], gclk[k], 1'b0);
        end
    end

    // block set and reset with polarity
    assign set_act = s_q.term[TERM_SET] ^ s_q.ctrl[CT_SETINV];
    assign rst_act = s_q.term[TERM_RST] ^ s_q.ctrl[CT_RSTINV];
    assign field = {~route_in, route_in};

    // per macrocell data and clock selection
    for (genvar m = 0; m < NUM_MC; m++)
    begin : g_mc
        localparam int G = (m / GRP) * GRP;
        localparam int ADJ = (m > 0) ? m - 1 : 0;
        logic [2:0] csel;
        logic inreg;
        assign csel = s_q.mccfg[m][MC_CLK +: 3];
        assign inreg = s_q.mccfg[m][MC_INREG] && !MC_IO_MASK[m];
        assign mc_data[m] = inreg ? s_q.io_s2[ADJ] :
            |(s_q.term[G +: GRP] & s_q.mccfg[m][MC_TSEL +: GRP]);
        assign mc_edge[m] = edge_v[csel];
        assign mc_lvl[m] = lvl_v[csel];
        assign mc_out[m] = (s_q.mccfg[m][MC_MODE +: 2] == CMS_COMB) ?
                           mc_data[m] : s_q.mcq[m];
    end

    // dedicated inputs, clocked by a selected global clock
    for (genvar i = 0; i < NUM_IN; i++)
    begin : g_in
        logic [1:0] ck;
        assign ck = s_q.incfg[i][IN_CLK +: 2];
        cms_input_cell u_cell (
            .clk(hclk),
            .rst_n(hresetn),
            .ce(ce),
            .pin(s_q.in_s2[i]),
            .cap(gedge[ck]),
            .lvl(gclk[ck]),
            .mode(s_q.incfg[i][IN_MODE +: 2]),
            .dout(in_to_matrix[i])
        );
    end

    // term mask memory, bus read steals the read port
    assign mem_if.raddr = (s_q.bst == CMS_BUS_MRD) ? s_q.baddr[8:4] :
                          s_q.sw_idx;
    assign mem_if.we = (s_q.bst == CMS_BUS_WR) && is_mask(s_q.baddr);
    assign mem_if.lane_we = 3'(3'h1 << s_q.baddr[3:2]);
    assign mem_if.waddr = s_q.baddr[8:4];
    assign mem_if.wdata = hwdata[LANE_W-1:0];

    cms_term_mem u_mem (
        .clk(hclk),
        .rst_n(hresetn),
        .ce(ce),
        .port(mem_if.ctl)
    );

    assign acc = hsel && htrans[1] && hready;

    // bus slave, term sweep, macrocells and pins
    always_comb
    begin
        logic [31:0] rd;
        s_d = s_q;
        rd = 32'h0;
        if (s_q.bst == CMS_BUS_WR)
        begin
            if (s_q.baddr == OFF_CTRL)
                s_d.ctrl = hwdata[CTRL_W-1:0];
            if (is_mc(s_q.baddr))
                s_d.mccfg[s_q.baddr[5:2]] = hwdata[MC_CFG_W-1:0];
            if (is_in(s_q.baddr))
                s_d.incfg[s_q.baddr[4:2]] = hwdata[IN_CFG_W-1:0];
        end
        unique case (s_q.bst)
            CMS_BUS_IDLE, CMS_BUS_WR, CMS_BUS_MDAT:
            begin
                s_d.bst = CMS_BUS_IDLE;
                if (acc)
                begin
                    s_d.baddr = haddr[11:0];
                    if (hwrite && hsize == HSIZE_WORD)
                        s_d.bst = CMS_BUS_WR;
                    else if (!hwrite && is_mask(haddr[11:0]))
                        s_d.bst = CMS_BUS_MRD;
                end
            end
            CMS_BUS_MRD: s_d.bst = CMS_BUS_MDAT;
        endcase
        // register reads see a write in the same cycle
        if (haddr[11:0] == OFF_CTRL)
            rd = {24'h0, s_d.ctrl};
        if (haddr[11:0] == OFF_STATUS)
            rd = {11'h0, in_to_matrix, s_q.fb};
        if (haddr[11:0] == OFF_PINS)
            rd = {11'h0, s_q.in_s2, s_q.io_s2};
        if (is_mc(haddr[11:0]))
            rd = {20'h0, s_d.mccfg[haddr[5:2]]};
        if (is_in(haddr[11:0]))
            rd = {28'h0, s_d.incfg[haddr[4:2]]};
        if (acc && !hwrite)
            s_d.hrdata = rd;
        // sweep all terms over the shared field
        s_d.ev_vld = 1'b0;
        if (s_q.bst != CMS_BUS_MRD)
        begin
            s_d.ev_vld = 1'b1;
            s_d.ev_idx = s_q.sw_idx;
            s_d.sw_idx = (s_q.sw_idx == TERM_LAST) ? '0 : s_q.sw_idx + 5'h1;
        end
        if (s_q.ev_vld)
            s_d.term[s_q.ev_idx] = cms_term_eval(mem_if.rdata, field);
        s_d.prev = src;
        for (int m = 0; m < NUM_MC; m++)
        begin
            s_d.mcq[m] = mc_next(s_q.mccfg[m][MC_MODE +: 2], s_q.mcq[m],
                                 mc_data[m], mc_edge[m], mc_lvl[m]);
            if (set_act)
                s_d.mcq[m] = 1'b1;
            if (rst_act)
                s_d.mcq[m] = 1'b0;
            s_d.fb[m] = mc_out[m];
            s_d.pino[m] = MC_IO_MASK[m] &
                          (mc_out[m] ^ s_q.mccfg[m][MC_OINV]);
            s_d.hold[m] = io_pin_oe[m] ? s_q.pino[m] : s_q.io_s2[m];
        end
        s_d.io_s1 = io_pin_i;
        s_d.io_s2 = s_q.io_s1;
        s_d.in_s1 = in_pin;
        s_d.in_s2 = s_q.in_s1;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            s_q <= SLICE_RST;
        else if (ce)
            s_q <= s_d;
    end

    // outputs
    assign hreadyout = (s_q.bst != CMS_BUS_MRD);
    assign hresp = 1'b0;
    assign hrdata = (s_q.bst == CMS_BUS_MDAT) ?
                    {8'h0, lane_of(mem_if.rdata, s_q.baddr[3:2])} : s_q.hrdata;
    assign mc_to_matrix = s_q.fb;
    assign pin_to_matrix = s_q.io_s2 & MC_IO_MASK;
    assign io_pin_o = s_q.pino;
    assign io_keep_o = s_q.hold;
    for (genvar m = 0; m < NUM_MC; m++)
    begin : g_oe
        assign io_pin_oe[m] = MC_IO_MASK[m] & s_q.mccfg[m][MC_OE];
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence s_two_ce;
        ce ##1 ce;
    endsequence

    property p_rst_zero;
        ce && rst_act |=> s_q.mcq == '0;
    endproperty
    a_rst_zero: assert property (p_rst_zero)
        else $error("reset term did not clear registers");

    property p_set_pol;
        ce && (s_q.term[TERM_SET] != s_q.ctrl[CT_SETINV]) && !rst_act
            |=> &s_q.mcq;
    endproperty
    a_set_pol: assert property (p_set_pol)
        else $error("set term with polarity did not force ones");

    property p_t_toggle;
        ce && s_q.mccfg[2][MC_MODE +: 2] == CMS_TFF && mc_edge[2] &&
            !set_act && !rst_act
            |=> s_q.mcq[2] == ($past(s_q.mcq[2]) ^ $past(mc_data[2]));
    endproperty
    a_t_toggle: assert property (p_t_toggle)
        else $error("toggle register wrong after edge");

    property p_d_cap;
        ce && s_q.mccfg[1][MC_MODE +: 2] == CMS_DFF && !set_act && !rst_act
            |=> s_q.mcq[1] == ($past(mc_edge[1]) ? $past(mc_data[1]) :
                               $past(s_q.mcq[1]));
    endproperty
    a_d_cap: assert property (p_d_cap)
        else $error("d register captured without edge or missed edge");

    property p_edge_pol;
        ce && edge_v[0] |-> global_sync_clock_a == !s_q.ctrl[CT_FALL];
    endproperty
    a_edge_pol: assert property (p_edge_pol)
        else $error("edge taken against block polarity");

    property p_out_inv;
        ce |=> io_pin_o[0] == (mc_to_matrix[0] ^ $past(s_q.mccfg[0][MC_OINV]));
    endproperty
    a_out_inv: assert property (p_out_inv)
        else $error("pin level does not follow polarity mux");

    property p_buried_fb;
        ce |=> mc_to_matrix[1] == $past(mc_out[1]);
    endproperty
    a_buried_fb: assert property (p_buried_fb)
        else $error("buried output not sent to routing matrix");

    property p_pin_path;
        s_two_ce |=> pin_to_matrix == ($past(io_pin_i, 2) & MC_IO_MASK);
    endproperty
    a_pin_path: assert property (p_pin_path)
        else $error("pin input path not independent of feedback");

    property p_keep;
        ce && io_pin_oe[0] |=> io_keep_o[0] == $past(io_pin_o[0]);
    endproperty
    a_keep: assert property (p_keep)
        else $error("keeper did not take last driven level");
endmodule

// *** testbench/cms_far_model.sv ***
// far side model: routing matrix drive and pin wires with keeper
`timescale 1ns/100ps
module cms_far_model
    import cms_pkg::*;
(
    input wire logic [NUM_ROUTE-1:0] route_set,
    input wire logic [NUM_IN-1:0] pin_set,
    input wire logic [NUM_MC-1:0] ext_en,
    input wire logic [NUM_MC-1:0] ext_val,
    input wire logic [NUM_MC-1:0] io_pin_o,
    input wire logic [NUM_MC-1:0] io_pin_oe,
    input wire logic [NUM_MC-1:0] io_keep_o,
    output logic [NUM_IN-1:0] in_pin,
    output logic [NUM_MC-1:0] io_pin_i,
    output logic [NUM_ROUTE-1:0] route_in
);
    // matrix signals and dedicated pins follow the bench
    assign route_in = route_set;
    assign in_pin = pin_set;
    // device drive wins, then outside drive, else the weak keeper
    assign io_pin_i = (io_pin_oe & io_pin_o) |
        (~io_pin_oe & ext_en & ext_val) |
        (~io_pin_oe & ~ext_en & io_keep_o);
endmodule

// *** testbench/cms_slice_tb_top.sv ***
// self-checking bench for the macrocell slice
`timescale 1ns/100ps
module cms_slice_tb_top;
    import cms_pkg::*;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic hreadyout, hresp;
    logic [31:0] hrdata, rd;
    logic [NUM_ROUTE-1:0] route_set = '0;
    logic [NUM_ROUTE-1:0] route_in;
    logic [NUM_IN-1:0] pin_set = '0;
    logic [NUM_IN-1:0] in_pin, in_to_matrix;
    logic [NUM_MC-1:0] ext_en = '0;
    logic [NUM_MC-1:0] ext_val = '0;
    logic [NUM_MC-1:0] io_pin_i, io_pin_o, io_pin_oe, io_keep_o;
    logic [NUM_MC-1:0] mc_to_matrix, pin_to_matrix;
    logic [11:0] ra [6] = '{OFF_CTRL, OFF_STATUS, OFF_MC, OFF_IN,
        OFF_MASK, 12'h100};
    int errors = 0;
    int cmp_count = 0;

    cms_slice cms_slice_i (.hclk(hclk), .hresetn(hresetn), .ce(1'b1),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(HSIZE_WORD), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .route_in(route_in), .in_pin(in_pin), .io_pin_i(io_pin_i),
        .io_pin_o(io_pin_o), .io_pin_oe(io_pin_oe), .io_keep_o(io_keep_o),
        .mc_to_matrix(mc_to_matrix), .pin_to_matrix(pin_to_matrix),
        .in_to_matrix(in_to_matrix));
    cms_far_model cms_far_model_i (.route_set(route_set),
        .pin_set(pin_set), .ext_en(ext_en), .ext_val(ext_val),
        .io_pin_o(io_pin_o), .io_pin_oe(io_pin_oe), .io_keep_o(io_keep_o),
        .in_pin(in_pin), .io_pin_i(io_pin_i), .route_in(route_in));

    // free-running bus clock
    always #10 hclk = ~hclk;

    // counts, verdict, end of run
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // compare one word
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            errors++;
            $display("unexpected at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // compare one pin level where it is settled
    task automatic pchk(input logic got, input logic exp);
        @(negedge hclk);
        chk({31'h0, got}, {31'h0, exp});
        @(posedge hclk);
    endtask

    // wait for hready high at an edge, keep read data of that edge
    task automatic wait_rdy();
        int n;
        n = 0;
        @(negedge hclk);
        while (hreadyout !== 1'b1 && n < 50)
        begin
            @(negedge hclk);
            n++;
        end
        if (n >= 50)
        begin
            errors++;
            final_report();
        end
        rd = hrdata;
        @(posedge hclk);
    endtask

    // one single-word transfer: address phase, then data phase
    task automatic xfer(input logic w, input logic [31:0] a,
        input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        wait_rdy();
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
    endtask

    // read until masked value matches, bounded
    task automatic poll(input logic [31:0] a, input logic [31:0] m,
        input logic [31:0] e);
        int n;
        n = 0;
        xfer(1'b0, a, 32'h0);
        while ((rd & m) !== e && n < 60)
        begin
            xfer(1'b0, a, 32'h0);
            n++;
        end
        chk(rd & m, e);
    endtask

    // one edge on global clock a after the pin syncs
    task automatic clk_a(input logic v);
        pin_set[1] <= v;
        repeat (8) @(posedge hclk);
    endtask

    // main sequence
    initial
    begin
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        foreach (ra[k])
            poll({20'h0, ra[k]}, 32'hffffffff, 32'h0);
        pchk(hresp, 1'b0);
        xfer(1'b1, OFF_CTRL, 32'hf0);
        poll(OFF_CTRL, 32'hffffffff, 32'hf0);
        xfer(1'b1, 32'h100, 32'hffffffff);
        poll(32'h100, 32'hffffffff, 32'h0);
        xfer(1'b1, OFF_CTRL, 32'h0);
        $display("test registers done");
        xfer(1'b1, OFF_MASK, 32'h1);
        poll(OFF_MASK, 32'hffffffff, 32'h1);
        xfer(1'b1, OFF_MC, 32'h140);
        route_set[0] <= 1'b1;
        poll(OFF_STATUS, 32'h1, 32'h1);
        pchk(io_pin_o[0], 1'b1);
        pchk(io_pin_oe[0], 1'b1);
        route_set[0] <= 1'b0;
        poll(OFF_STATUS, 32'h1, 32'h0);
        xfer(1'b1, OFF_MASK, 32'h0);
        xfer(1'b1, OFF_MASK + 32'h4, 32'h1000);
        poll(OFF_STATUS, 32'h1, 32'h1);
        xfer(1'b1, OFF_MC, 32'h160);
        repeat (8) @(posedge hclk);
        pchk(io_pin_o[0], 1'b0);
        poll(OFF_STATUS, 32'h1, 32'h1);
        $display("test terms done");
        xfer(1'b1, OFF_MC, 32'h120);
        poll(OFF_PINS, 32'h1, 32'h0);
        ext_en[0] <= 1'b1;
        ext_val[0] <= 1'b1;
        poll(OFF_PINS, 32'h1, 32'h1);
        pchk(pin_to_matrix[0], 1'b1);
        ext_en[0] <= 1'b0;
        repeat (4) @(posedge hclk);
        pchk(io_keep_o[0], 1'b1);
        $display("test pins done");
        // term 2 lies in the group of macrocell 2 and follows route bit 3
        route_set[3] <= 1'b1;
        xfer(1'b1, OFF_MASK + 32'h20, 32'h8);
        xfer(1'b1, OFF_MC + 32'h8, 32'h402);
        xfer(1'b1, OFF_MC + 32'h4, 32'h81);
        repeat (24) @(posedge hclk);
        clk_a(1'b1);
        poll(OFF_STATUS, 32'h6, 32'h6);
        clk_a(1'b0);
        clk_a(1'b1);
        poll(OFF_STATUS, 32'h4, 32'h0);
        xfer(1'b1, OFF_CTRL, 32'h1);
        clk_a(1'b0);
        poll(OFF_STATUS, 32'h4, 32'h4);
        clk_a(1'b1);
        poll(OFF_STATUS, 32'h4, 32'h4);
        route_set[3] <= 1'b0;
        repeat (24) @(posedge hclk);
        clk_a(1'b0);
        poll(OFF_STATUS, 32'h4, 32'h4);
        xfer(1'b1, OFF_CTRL, 32'h0);
        $display("test macrocell registers done");
        pin_set[0] <= 1'b1;
        poll(OFF_STATUS, 32'h10000, 32'h10000);
        xfer(1'b1, OFF_IN, 32'h1);
        pin_set[0] <= 1'b0;
        clk_a(1'b0);
        poll(OFF_STATUS, 32'h10000, 32'h10000);
        clk_a(1'b1);
        poll(OFF_STATUS, 32'h10000, 32'h0);
        $display("test inputs done");
        xfer(1'b1, OFF_MASK + 32'h100, 32'h2);
        xfer(1'b1, OFF_MASK + 32'h110, 32'h4);
        route_set[1] <= 1'b1;
        poll(OFF_STATUS, 32'h6, 32'h6);
        route_set[1] <= 1'b0;
        route_set[2] <= 1'b1;
        poll(OFF_STATUS, 32'h6, 32'h0);
        route_set[2] <= 1'b0;
        xfer(1'b1, OFF_CTRL, 32'h2);
        poll(OFF_STATUS, 32'h6, 32'h6);
        xfer(1'b1, OFF_CTRL, 32'h0);
        $display("test set reset done");
        final_report();
    end
endmodule
